// ### logic/nctr_pkg.sv
// constants for the uncacheable window and sdram timing register bank
// Functional notes
// RULE_01 - each window register holds a writable base address in bits 31..11
// RULE_02 - bit 10 enables a window; window acts only while set
// RULE_03 - size code bits 2..0 pick window length 2K up to 128K bytes
// RULE_04 - phase register bits 7..4 select read clock phase
// RULE_05 - phase register bits 3..0 select write clock phase
// RULE_06 - timing bit 15 sets write recovery, 0 one clock, 1 two clocks
// RULE_07 - timing bits 14..11 give row cycle clocks 1..15, code 0 reserved
// RULE_08 - timing bits 10..7 give precharge to activate clocks, code 0 reserved
// RULE_09 - timing bits 6..3 give activate to column clocks, code 0 reserved
// RULE_10 - first window register sits at offsets 50h..53h, same layout
// RULE_11 - second window register sits at offsets 54h..57h
// RULE_12 - access inside any enabled aligned window is flagged uncacheable
// RULE_13 - timing bits 2..0 ignore writes and read back reset value
package nctr_pkg;
  localparam int          NUM_WIN      = 4;
  localparam logic [7:0]  OFS_WIN1     = 8'h50;
  localparam logic [7:0]  OFS_WIN2     = 8'h54;
  localparam logic [7:0]  OFS_WIN3     = 8'h58;
  localparam logic [7:0]  OFS_WIN4     = 8'h5c;
  localparam logic [7:0]  OFS_PHASE    = 8'h66;
  localparam logic [7:0]  OFS_TIMING   = 8'h68;
  localparam logic [31:0] WIN_RST      = 32'h0000_0000;
  localparam logic [7:0]  PHASE_RST    = 8'h00;
  localparam logic [15:0] TIMING_RST   = 16'hc99f;
  localparam logic [15:0] TIMING_WMASK = 16'hfff8;
  localparam int          BASE_LSB     = 11;
  localparam int          EN_BIT       = 10;
  localparam int          WR_BIT       = 15;
  localparam logic [2:0]  SZ_RSV       = 3'h1;
  localparam int          SZ_MIN_LOG   = 11;
  localparam int          SZ_W         = 3;
  localparam int          PH_LANE_LSB  = 16;
  localparam int          PH_RD_LSB    = 4;
  localparam int          PH_WR_LSB    = 0;
  localparam int          FLD_W        = 4;
  localparam int          TRC_LSB      = 11;
  localparam int          TRP_LSB      = 7;
  localparam int          ACTIVATE_TO_COLUMN_CLOCKS_LSB     = 3;
  typedef enum logic [1:0] {NCTR_IDLE, NCTR_RESP} nctr_state_t;
endpackage : nctr_pkg

// ### logic/nctr_cfg_if.sv
// carrier between the bus front end and the window match logic
`timescale 1ns/1ns
interface nctr_cfg_if;
  logic [31:0] win [4];
  modport owner (output win);
  modport user  (input  win);
endinterface : nctr_cfg_if

// ### logic/nctr_match.sv
// address match against the uncacheable windows
`timescale 1ns/1ns
module nctr_match
  import nctr_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // windows
  nctr_cfg_if.user         cfg,
  // processor address
  input  wire logic [31:0] cpu_addr,
  output logic             uncached_r
);
  // mask of bits covered by the window; reserved code 001 treated as 2K
  function automatic logic [31:0] size_mask(input logic [2:0] code);
    logic [4:0] lg;
    lg = (code == 3'h0 || code == SZ_RSV) ? 5'(SZ_MIN_LOG) : 5'(SZ_MIN_LOG + int'(code) - 1); // RULE_03
    size_mask = (32'h1 << lg) - 32'h1;
  endfunction : size_mask

  logic [NUM_WIN-1:0] hit;
  genvar i;
  generate
    for (i = 0; i < NUM_WIN; i++)
    begin : g_win
      wire [31:0] mask = size_mask(cfg.win[i][SZ_W-1:0]);
      wire [31:0] base = {cfg.win[i][31:BASE_LSB], {BASE_LSB{1'b0}}};
      // base aligned down to the window size
      assign hit[i] = cfg.win[i][EN_BIT] && // RULE_02
        ((cpu_addr & ~mask) == (base & ~mask)); // RULE_12
    end
  endgenerate
  wire uncached_nxt = |hit;

  // registered so the output leaves a flop
  always_ff @(posedge mclk or negedge rstn)
    if (!rstn) uncached_r <= 1'b0;
    else       uncached_r <= uncached_nxt;

  hit_follows_a: assert property (@(posedge mclk) disable iff (!rstn) // RULE_12
    uncached_r == $past(uncached_nxt)) else $error("uncached flag lags");
  // with every window off nothing may be flagged, whatever the address
  off_no_hit_a: assert property (@(posedge mclk) disable iff (!rstn) // RULE_02
    !(cfg.win[0][EN_BIT] || cfg.win[1][EN_BIT] || cfg.win[2][EN_BIT] || cfg.win[3][EN_BIT])
    |=> !uncached_r)
    else $error("uncached flag with all windows off");
  cov_hit: cover property (@(posedge mclk) disable iff (!rstn) uncached_r);
endmodule : nctr_match

// ### logic/nctr_regs.sv
// configuration register bank: windows, clock phase and sdram timing
`timescale 1ns/1ns
module nctr_regs
  import nctr_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // configuration space access, dword addressed, byte enables
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic [31:0]      cfg_rdata_r,
  output logic             cfg_ack_r,
  // processor address check
  input  wire logic [31:0] cpu_addr,
  output logic             uncached_r,
  // to the dram controller and clock generator
  output logic [3:0]       read_clock_phase_r,
  output logic [3:0]       write_clock_phase_r,
  output logic             write_recovery_clocks_r,
  output logic [3:0]       row_cycle_clocks_r,
  output logic [3:0]       precharge_to_activate_clocks_r,
  output logic [3:0]       activate_to_column_clocks_r
);
  nctr_cfg_if cfg ();
  logic [31:0] win_r [NUM_WIN];
  logic [7:0]  phase_r;
  logic [15:0] timing_r;
  nctr_state_t st_r;

  // merge write data under byte enables
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    for (int b = 0; b < 4; b++)
      if (be[b]) old[8*b +: 8] = nw[8*b +: 8];
    merge = old;
  endfunction : merge

  // decode on the dword, phase and timing sit in separate dwords 64h..67h and 68h..6bh
  wire [7:0] dw = {cfg_addr[7:2], 2'b00};
  wire sel_w1  = dw == OFS_WIN1; // RULE_10
  wire sel_w2  = dw == OFS_WIN2; // RULE_11
  wire sel_w3  = dw == OFS_WIN3;
  wire sel_w4  = dw == OFS_WIN4;
  wire sel_ph  = dw == {OFS_PHASE[7:2], 2'b00};
  wire sel_tm  = dw == OFS_TIMING;
  wire [3:0] sel_win = {sel_w4, sel_w3, sel_w2, sel_w1};

  // phase sits in byte lane 2 of its dword
  wire [31:0] ph_word   = 32'(phase_r) << PH_LANE_LSB;
  wire [31:0] ph_merge  = merge(ph_word, cfg_wdata, cfg_be);
  wire [7:0]  phase_nxt = (cfg_wr && sel_ph) ? ph_merge[PH_LANE_LSB +: 8] : phase_r; // RULE_04 RULE_05
  wire [31:0] tm_merge = merge({16'h0000, timing_r}, cfg_wdata, cfg_be);
  // reserved low bits keep reset value
  wire [15:0] timing_nxt = (cfg_wr && sel_tm) ?
    ((tm_merge[15:0] & TIMING_WMASK) | (TIMING_RST & ~TIMING_WMASK)) : timing_r; // RULE_13

  wire [31:0] rd_mux = sel_w1 ? win_r[0] : sel_w2 ? win_r[1] : sel_w3 ? win_r[2] :
                       sel_w4 ? win_r[3] : sel_ph ? ph_word :
                       sel_tm ? {16'h0000, timing_r} : 32'h0000_0000;
  wire busy = (st_r == NCTR_RESP);
  wire take = (cfg_wr || cfg_rd) && !busy;
  // a read alongside a write returns the old value, so read checks key on pure reads
  wire wr_take = take && cfg_wr;
  wire rd_take = take && cfg_rd && !cfg_wr;

  // windows, fully writable under byte enables
  genvar i;
  generate
    for (i = 0; i < NUM_WIN; i++)
    begin : g_w
      always_ff @(posedge mclk or negedge rstn)
        if (!rstn) win_r[i] <= WIN_RST;
        else if (wr_take && sel_win[i]) win_r[i] <= merge(win_r[i], cfg_wdata, cfg_be); // RULE_01 RULE_02 RULE_03
      assign cfg.win[i] = win_r[i];
    end
  endgenerate

  // phase and timing move only on a taken access
  always_ff @(posedge mclk or negedge rstn)
    if (!rstn)
    begin
      phase_r  <= PHASE_RST;
      timing_r <= TIMING_RST;
    end
    else if (take)
    begin
      phase_r  <= phase_nxt;
      timing_r <= timing_nxt;
    end

  // one access per two cycles keeps ack a clean single pulse
  always_ff @(posedge mclk or negedge rstn)
    if (!rstn)
      st_r <= NCTR_IDLE;
    else
      case (st_r)
        NCTR_IDLE: st_r <= take ? NCTR_RESP : NCTR_IDLE;
        NCTR_RESP: st_r <= NCTR_IDLE;
        default:   st_r <= NCTR_IDLE;
      endcase

  // response: read data stands only while ack does, zero otherwise
  always_ff @(posedge mclk or negedge rstn)
    if (!rstn)
    begin
      cfg_ack_r   <= 1'b0;
      cfg_rdata_r <= 32'h0000_0000;
    end
    else
    begin
      cfg_ack_r   <= take;
      cfg_rdata_r <= (take && cfg_rd) ? rd_mux : 32'h0000_0000;
    end

  // field outputs straight from the registers, no logic in between
  assign read_clock_phase_r             = phase_r[PH_RD_LSB +: FLD_W];   // RULE_04
  assign write_clock_phase_r            = phase_r[PH_WR_LSB +: FLD_W];   // RULE_05
  assign write_recovery_clocks_r        = timing_r[WR_BIT];              // RULE_06
  assign row_cycle_clocks_r             = timing_r[TRC_LSB +: FLD_W];    // RULE_07
  assign precharge_to_activate_clocks_r = timing_r[TRP_LSB +: FLD_W];    // RULE_08
  assign activate_to_column_clocks_r    = timing_r[ACTIVATE_TO_COLUMN_CLOCKS_LSB +: FLD_W];   // RULE_09

  nctr_match u_match (
    .mclk       (mclk),
    .rstn       (rstn),
    .cfg        (cfg.user),
    .cpu_addr   (cpu_addr),
    .uncached_r (uncached_r)
  );

  // bus response checks
  ack_one_a: assert property (@(posedge mclk) disable iff (!rstn)
    cfg_ack_r
    |=> !cfg_ack_r)
    else $error("ack longer than one cycle");
  ack_take_a: assert property (@(posedge mclk) disable iff (!rstn)
    take
    |=> cfg_ack_r)
    else $error("taken access not acknowledged");
  st_ack_a: assert property (@(posedge mclk) disable iff (!rstn)
    cfg_ack_r
    |-> busy)
    else $error("ack outside the refused cycle");
  rdata_idle_a: assert property (@(posedge mclk) disable iff (!rstn)
    !cfg_ack_r
    |-> cfg_rdata_r == 32'h0000_0000)
    else $error("read data without ack");
  rd_unmapped_a: assert property (@(posedge mclk) disable iff (!rstn)
    rd_take && !(|sel_win) && !sel_ph && !sel_tm
    |=> cfg_rdata_r == 32'h0000_0000)
    else $error("unmapped read not zero");

  // window registers
  win1_write_a: assert property (@(posedge mclk) disable iff (!rstn) // RULE_10
    wr_take && sel_w1 && cfg_be == 4'hf
    |=> win_r[0] == $past(cfg_wdata))
    else $error("window one write lost");
  win_write_a: assert property (@(posedge mclk) disable iff (!rstn) // RULE_11
    wr_take && sel_w2 && cfg_be == 4'hf
    |=> win_r[1] == $past(cfg_wdata))
    else $error("window two write lost");
  win3_write_a: assert property (@(posedge mclk) disable iff (!rstn) // RULE_01
    wr_take && sel_w3 && cfg_be == 4'hf
    |=> win_r[2] == $past(cfg_wdata))
    else $error("window three write lost");
  en_write_a: assert property (@(posedge mclk) disable iff (!rstn) // RULE_02
    wr_take && sel_w4 && cfg_be[1]
    |=> win_r[3][EN_BIT] == $past(cfg_wdata[EN_BIT]))
    else $error("window enable write lost");
  size_write_a: assert property (@(posedge mclk) disable iff (!rstn) // RULE_03
    wr_take && sel_w4 && cfg_be[0]
    |=> win_r[3][SZ_W-1:0] == $past(cfg_wdata[SZ_W-1:0]))
    else $error("window size write lost");
  win_hold_a: assert property (@(posedge mclk) disable iff (!rstn) // RULE_01
    !wr_take
    |=> $stable(win_r[0]) && $stable(win_r[1]) && $stable(win_r[2]) && $stable(win_r[3]))
    else $error("window changed without a write");

  // clock phase register
  phase_write_a: assert property (@(posedge mclk) disable iff (!rstn) // RULE_04
    wr_take && sel_ph && cfg_be[2]
    |=> read_clock_phase_r == $past(cfg_wdata[PH_LANE_LSB + PH_RD_LSB +: FLD_W])
        && write_clock_phase_r == $past(cfg_wdata[PH_LANE_LSB + PH_WR_LSB +: FLD_W]))
    else $error("phase write lost");
  phase_hold_a: assert property (@(posedge mclk) disable iff (!rstn) // RULE_05
    !(cfg_wr && sel_ph)
    |=> $stable(phase_r))
    else $error("phase changed without a write");

  // sdram timing register
  twr_write_a: assert property (@(posedge mclk) disable iff (!rstn) // RULE_06
    wr_take && sel_tm && cfg_be[1]
    |=> write_recovery_clocks_r == $past(cfg_wdata[WR_BIT]))
    else $error("write recovery not updated");
  trc_write_a: assert property (@(posedge mclk) disable iff (!rstn) // RULE_07
    wr_take && sel_tm && cfg_be[1]
    |=> row_cycle_clocks_r == $past(cfg_wdata[TRC_LSB +: FLD_W]))
    else $error("row cycle write lost");
  trc_hold_a: assert property (@(posedge mclk) disable iff (!rstn) // RULE_07
    !(cfg_wr && sel_tm)
    |=> $stable(row_cycle_clocks_r))
    else $error("row cycle drifted");
  trp_write_a: assert property (@(posedge mclk) disable iff (!rstn) // RULE_08
    wr_take && sel_tm && cfg_be[1:0] == 2'h3
    |=> precharge_to_activate_clocks_r == $past(cfg_wdata[TRP_LSB +: FLD_W]))
    else $error("precharge to activate write lost");
  activate_to_column_clocks_write_a: assert property (@(posedge mclk) disable iff (!rstn) // RULE_09
    wr_take && sel_tm && cfg_be[0]
    |=> activate_to_column_clocks_r == $past(cfg_wdata[ACTIVATE_TO_COLUMN_CLOCKS_LSB +: FLD_W]))
    else $error("activate to column write lost");
  rsvd_const_a: assert property (@(posedge mclk) disable iff (!rstn) // RULE_13
    1'b1
    |-> timing_r[ACTIVATE_TO_COLUMN_CLOCKS_LSB-1:0] == TIMING_RST[ACTIVATE_TO_COLUMN_CLOCKS_LSB-1:0])
    else $error("reserved timing bits moved");
  rd_timing_a: assert property (@(posedge mclk) disable iff (!rstn) // RULE_09
    rd_take && sel_tm
    |=> cfg_rdata_r[WR_BIT:ACTIVATE_TO_COLUMN_CLOCKS_LSB] == {write_recovery_clocks_r, row_cycle_clocks_r,
        precharge_to_activate_clocks_r, activate_to_column_clocks_r})
    else $error("timing readback wrong");

  // main scenarios
  cov_wr_win: cover property (@(posedge mclk) disable iff (!rstn) take && cfg_wr && sel_w3);
  cov_rd_tm: cover property (@(posedge mclk) disable iff (!rstn) take && cfg_rd && sel_tm);
  cov_b2b: cover property (@(posedge mclk) disable iff (!rstn) take ##2 take);
endmodule : nctr_regs

// ### dv/noncache_and_sdram_timing_regs_tb.sv
// self-checking bench for the window, clock phase and sdram timing registers
`timescale 1ns/1ns
module noncache_and_sdram_timing_regs_tb;
  import nctr_pkg::*;
  logic        mclk, rstn, cfg_wr, cfg_rd, cfg_ack_r, uncached_r, write_recovery_clocks_r;
  logic [7:0]  cfg_addr;
  logic [3:0]  cfg_be, read_clock_phase_r, write_clock_phase_r, row_cycle_clocks_r;
  logic [3:0]  precharge_to_activate_clocks_r, activate_to_column_clocks_r;
  logic [31:0] cfg_wdata, cfg_rdata_r, cpu_addr, d, b, m, ins;
  logic [32:0] rq [$];
  logic [32:0] e;
  int          fails, checked, cyc, i, lg;

  nctr_regs dut (.mclk, .rstn, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be, .cfg_wdata,
    .cfg_rdata_r, .cfg_ack_r, .cpu_addr, .uncached_r, .read_clock_phase_r,
    .write_clock_phase_r, .write_recovery_clocks_r, .row_cycle_clocks_r,
    .precharge_to_activate_clocks_r, .activate_to_column_clocks_r);

  // 20 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task results;
    if (fails == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results

  task chk(input string n, input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, x, s);
    end
  endtask : chk

  // request held until its ack is seen; the refused follow-on cycle covers the drop
  task acc(input logic w, input logic [7:0] a, input logic [3:0] be, input logic [31:0] wd,
           input logic [31:0] x);
    @(posedge mclk);
    cfg_wr    <= w;
    cfg_rd    <= !w;
    cfg_addr  <= a;
    cfg_be    <= be;
    cfg_wdata <= wd;
    rq.push_back({!w, x});
    @(negedge mclk);
    while (cfg_ack_r !== 1'b1) @(negedge mclk);
    @(posedge mclk);
    cfg_wr <= 1'b0;
    cfg_rd <= 1'b0;
  endtask : acc

  task probe(input logic [31:0] a, input logic x);
    @(posedge mclk);
    cpu_addr <= a;
    @(posedge mclk);
    @(negedge mclk);
    chk("uncached", {31'h0, uncached_r}, {31'h0, x});
  endtask : probe

  // read results compared in order as acks appear
  always @(negedge mclk)
    if (cfg_ack_r === 1'b1 && rq.size() > 0)
    begin
      e = rq.pop_front();
      if (e[32]) chk("rdata", cfg_rdata_r, e[31:0]);
    end

  // hang guard, the whole run needs well under a thousand cycles
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc > 4000)
    begin
      fails++;
      results();
    end
  end

  initial
  begin
    {cfg_wr, cfg_rd, cfg_addr, cfg_be, cfg_wdata, cpu_addr} = '0;
    rstn = 1'b0;
    void'($urandom(95615));
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    for (i = 0; i < 4; i++) acc(1'b0, 8'h50 + 8'(4 * i), 4'hf, 32'h0, WIN_RST);
    acc(1'b0, OFS_PHASE & 8'hfc, 4'hf, 32'h0, {8'h0, PHASE_RST, 16'h0});
    acc(1'b0, OFS_TIMING, 4'hf, 32'h0, {16'h0, TIMING_RST});
    for (i = 0; i < 4; i++)
    begin
      d = $urandom;
      acc(1'b1, 8'h50 + 8'(4 * i), 4'hf, d, 32'h0);
      acc(1'b0, 8'h50 + 8'(4 * i), 4'hf, 32'h0, d);
    end
    d = $urandom;
    acc(1'b1, 8'h64, 4'h4, d, 32'h0);
    acc(1'b0, 8'h64, 4'hf, 32'h0, {8'h0, d[23:16], 16'h0});
    chk("rd_phase", {28'h0, read_clock_phase_r}, {28'h0, d[23:20]});
    chk("wr_phase", {28'h0, write_clock_phase_r}, {28'h0, d[19:16]});
    for (i = 0; i < 3; i++)
    begin
      d = (i == 0) ? 32'h0000_0000 : $urandom;
      acc(1'b1, OFS_TIMING, 4'h3, d, 32'h0);
      acc(1'b0, OFS_TIMING, 4'hf, 32'h0, {16'h0, d[15:3], TIMING_RST[2:0]});
      chk("recovery", {31'h0, write_recovery_clocks_r}, {31'h0, d[15]});
      chk("row_cycle", {28'h0, row_cycle_clocks_r}, {28'h0, d[14:11]});
      chk("pre_act", {28'h0, precharge_to_activate_clocks_r}, {28'h0, d[10:7]});
      chk("act_col", {28'h0, activate_to_column_clocks_r}, {28'h0, d[6:3]});
    end
    acc(1'b1, 8'h70, 4'hf, $urandom, 32'h0);
    acc(1'b0, 8'h70, 4'hf, 32'h0, 32'h0);
    // mid-run reset while the registers hold values other than their reset ones
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    acc(1'b0, OFS_WIN4, 4'hf, 32'h0, WIN_RST);
    acc(1'b0, OFS_PHASE & 8'hfc, 4'hf, 32'h0, {8'h0, PHASE_RST, 16'h0});
    acc(1'b0, OFS_TIMING, 4'hf, 32'h0, {16'h0, TIMING_RST});
    chk("row_cycle", {28'h0, row_cycle_clocks_r}, {28'h0, TIMING_RST[14:11]});
    for (i = 0; i < 4; i++) acc(1'b1, 8'h50 + 8'(4 * i), 4'hf, 32'h0, 32'h0);
    // every size code, one window at a time so no other window can match
    for (i = 0; i < 8; i++)
    begin
      d = $urandom;
      b = {d[31:11], 11'h0};
      lg = (i < 2) ? 11 : 10 + i;
      m = (32'h1 << lg) - 32'h1;
      ins = (b & ~m) | ($urandom & m);
      acc(1'b1, 8'h50 + 8'(4 * (i % 4)), 4'hf, {b[31:11], 1'b1, 7'h0, 3'(i)}, 32'h0);
      probe(ins, 1'b1);
      probe((b & ~m) + m + 32'h1, 1'b0);
      acc(1'b1, 8'h50 + 8'(4 * (i % 4)), 4'hf, {b[31:11], 1'b0, 7'h0, 3'(i)}, 32'h0);
      probe(ins, 1'b0);
      acc(1'b1, 8'h50 + 8'(4 * (i % 4)), 4'hf, 32'h0, 32'h0);
    end
    repeat (3) @(posedge mclk);
    results();
  end
endmodule : noncache_and_sdram_timing_regs_tb
